// ---- hdl/phy_control_a_regs.vh ----
// constants for the upper half of control register a
// Summary of operation
// - noise timing enable applies noise timing even in maintenance state
// - noise timer reloads from noise max on idle to noise/active/unknown
// - noise wide mode bypasses 2-bit prescaler, 16-bit timer, tick per 80 ns
// - connection wide mode bypasses 8-bit prescaler, 16-bit timer, tick per 80 ns
// - both wide mode bits writable only in off or maintenance state
// - in maintenance or override, scrub request selects idle onto receive bytes
// - scrub request always writable but acts only in maintenance or override
// - symbol transmit output follows only the maintenance line state select
// - parity enable checks even parity on ten transmit byte lines
// - violation mode clear: event on every violation counter increment
// - min idle mode set: event only when gap counter reaches 16
// - min idle mode clear: event on every gap counter increment
// - min idle mode leaves minimum detector events unaffected
// - loopback bit drives the active-low external loop pin low
// - every register bit clears to zero on reset
// - restricted bits ignore writes outside off or maintenance state
// - register sits at address 00 and is readable and writable
`ifndef PHY_CONTROL_A_REGS_VH
`define PHY_CONTROL_A_REGS_VH
`define PHY_CONTROL_A_ADDR 5'h00
`define PHY_CONTROL_A_RESET 16'h0000
`define PHY_CONTROL_A_WMASK 16'h7F80
`define BIT_NOISE_TIMING 14
`define BIT_NOISE_WIDE 13
`define BIT_CONN_WIDE 12
`define BIT_SCRUB_REQ 11
`define BIT_PARITY_EN 10
`define BIT_VIOL_OVF 9
`define BIT_MINI_OVF 8
`define BIT_LOOPBACK 7
`define LS_IDLE 2'h0
`define LS_NOISE 2'h1
`define LS_ACTIVE 2'h2
`define LS_UNKNOWN 2'h3
`define NOISE_PRESCALE 2'h3
`define CONN_PRESCALE 8'hFF
`define IDLE_BYTE 10'h3FF
`endif

// ---- hdl/phy_control_reg_a_upper.v ----
// upper half of control register a with the logic its bits steer
`include "phy_control_a_regs.vh"
module phy_control_reg_a_upper (
  // clock, reset, enable
  input wire i_clk,
  input wire i_reset,
  input wire i_ce,
  // register access, one-cycle strobes
  input wire [4:0] i_addr,
  input wire i_wr,
  input wire i_rd,
  input wire [15:0] i_wdata,
  output reg [15:0] o_rdata,
  // connection management state
  input wire i_cm_off,
  input wire i_cm_maintenance_state,
  input wire i_cm_noise_timing,
  input wire i_configuration_override,
  // line state and noise max reload
  input wire [1:0] i_line_state,
  input wire [15:0] i_noise_max_reload,
  // receive path
  input wire [9:0] i_rx_data,
  output reg [9:0] o_rx_byte,
  // transmit path
  input wire [9:0] i_mac_transmit_byte,
  input wire [4:0] i_tx_symbol,
  input wire [4:0] i_maintenance_symbol,
  input wire i_use_maintenance_symbol,
  output reg [4:0] o_symbol_transmit_out,
  output reg o_parity_error,
  // counter events
  input wire i_violation_detected,
  input wire i_min_gap_detected,
  input wire i_min_detector_event,
  output reg o_violation_count_event,
  output reg o_minimum_idle_count_event,
  // timers and external loop pin
  output reg [15:0] o_noise_event_timer,
  output reg [15:0] o_connection_timer,
  output reg o_noise_timer_expired_flag,
  output reg o_external_loop_pin_n
);

  reg [15:0] phy_control_a;
  reg [1:0] noise_prescale;
  reg [7:0] conn_prescale;
  reg [1:0] last_line_state;
  reg noise_running;
  reg [7:0] violation_symbol_counter;
  reg [3:0] minimum_idle_counter;
  reg [15:0] next_control;
  wire sel;
  wire restricted_ok;
  wire noise_active;
  wire noise_tick;
  wire conn_tick;
  wire left_idle;
  wire scrub_active;
  wire parity_odd;

  // timer step shared by both 16-bit timers
  function [15:0] inc16;
    input [15:0] value;
    begin
      inc16 = value + 16'h0001;
    end
  endfunction

  // step shared by the connection prescaler and the violation counter
  function [7:0] inc8;
    input [7:0] value;
    begin
      inc8 = value + 8'h01;
    end
  endfunction

  // step for the minimum idle gap counter
  function [3:0] inc4;
    input [3:0] value;
    begin
      inc4 = value + 4'h1;
    end
  endfunction

  assign sel = (i_addr == `PHY_CONTROL_A_ADDR);
  assign restricted_ok = i_cm_off | i_cm_maintenance_state;
  assign noise_active = i_cm_noise_timing |
    (i_cm_maintenance_state & phy_control_a[`BIT_NOISE_TIMING]);
  assign noise_tick = phy_control_a[`BIT_NOISE_WIDE] | (noise_prescale == `NOISE_PRESCALE);
  assign conn_tick = phy_control_a[`BIT_CONN_WIDE] | (conn_prescale == `CONN_PRESCALE);
  assign left_idle = (last_line_state == `LS_IDLE) && (i_line_state != `LS_IDLE);
  // scrub request only acts in maintenance or under override
  assign scrub_active = (i_cm_maintenance_state | i_configuration_override) & phy_control_a[`BIT_SCRUB_REQ];
  assign parity_odd = ^i_mac_transmit_byte;

  always @*
  begin
    next_control = (i_wdata & `PHY_CONTROL_A_WMASK) | (phy_control_a & ~`PHY_CONTROL_A_WMASK);
    if (!restricted_ok)
    begin
      next_control[`BIT_NOISE_WIDE] = phy_control_a[`BIT_NOISE_WIDE];
      next_control[`BIT_CONN_WIDE] = phy_control_a[`BIT_CONN_WIDE];
    end
    next_control[15] = 1'b0;
  end

  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      phy_control_a <= `PHY_CONTROL_A_RESET;
      o_rdata <= 16'h0000;
      noise_prescale <= 2'h0;
      conn_prescale <= 8'h00;
      last_line_state <= `LS_IDLE;
      noise_running <= 1'b0;
      violation_symbol_counter <= 8'h00;
      minimum_idle_counter <= 4'h0;
      o_rx_byte <= 10'h000;
      o_symbol_transmit_out <= 5'h00;
      o_parity_error <= 1'b0;
      o_violation_count_event <= 1'b0;
      o_minimum_idle_count_event <= 1'b0;
      o_noise_event_timer <= 16'h0000;
      o_connection_timer <= 16'h0000;
      o_noise_timer_expired_flag <= 1'b0;
      o_external_loop_pin_n <= 1'b1;
    end
    else if (i_ce)
    begin
      if (sel && i_wr)
      begin
        phy_control_a <= next_control;
      end
      if (sel && i_rd)
      begin
        o_rdata <= phy_control_a;
      end
      else
      begin
        o_rdata <= 16'h0000;
      end
      o_external_loop_pin_n <= ~phy_control_a[`BIT_LOOPBACK];

      // scrub multiplexer
      if (scrub_active)
      begin
        o_rx_byte <= `IDLE_BYTE;
      end
      else
      begin
        o_rx_byte <= i_rx_data;
      end

      // transmit symbols ignore scrub request
      if (i_use_maintenance_symbol)
      begin
        o_symbol_transmit_out <= i_maintenance_symbol;
      end
      else
      begin
        o_symbol_transmit_out <= i_tx_symbol;
      end
      o_parity_error <= phy_control_a[`BIT_PARITY_EN] & parity_odd;

      // violation counter
      o_violation_count_event <= 1'b0;
      if (i_violation_detected)
      begin
        violation_symbol_counter <= inc8(violation_symbol_counter);
        if (!phy_control_a[`BIT_VIOL_OVF])
        begin
          o_violation_count_event <= 1'b1;
        end
        else if (violation_symbol_counter == 8'hFF)
        begin
          o_violation_count_event <= 1'b1;
        end
      end

      // minimum idle gap counter; detector events pass regardless of mode
      o_minimum_idle_count_event <= i_min_detector_event;
      if (i_min_gap_detected)
      begin
        minimum_idle_counter <= inc4(minimum_idle_counter);
        if (!phy_control_a[`BIT_MINI_OVF])
        begin
          o_minimum_idle_count_event <= 1'b1;
        end
        else if (minimum_idle_counter == 4'hF)
        begin
          o_minimum_idle_count_event <= 1'b1;
        end
      end

      // connection timer
      conn_prescale <= phy_control_a[`BIT_CONN_WIDE] ? 8'h00 : inc8(conn_prescale);
      if (conn_tick)
      begin
        o_connection_timer <= inc16(o_connection_timer);
      end

      // noise event timer counts up to all ones from the reload value
      last_line_state <= i_line_state;
      noise_prescale <= phy_control_a[`BIT_NOISE_WIDE] ? 2'h0 : noise_prescale + 2'h1;
      o_noise_timer_expired_flag <= 1'b0;
      if (noise_active && left_idle)
      begin
        o_noise_event_timer <= i_noise_max_reload;
        noise_running <= 1'b1;
      end
      else if (i_line_state == `LS_IDLE || !noise_active)
      begin
        noise_running <= 1'b0;
      end
      else if (noise_running && noise_tick)
      begin
        if (o_noise_event_timer == 16'hFFFF)
        begin
          o_noise_timer_expired_flag <= 1'b1;
          noise_running <= 1'b0;
        end
        else
        begin
          o_noise_event_timer <= inc16(o_noise_event_timer);
        end
      end
    end
  end

endmodule

// ---- tb/np_model.sv ----
// node processor model issuing single register accesses
module np_model (
  input wire logic i_clk,
  output logic [4:0] addr,
  output logic wr, rd,
  output logic [15:0] wdata,
  input wire logic [15:0] rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {addr, wr, rd, wdata} = 23'h000000;
  task automatic access(input logic w, input logic [4:0] a, input logic [15:0] d,
    output logic [15:0] q);
    @(negedge i_clk);
    {addr, wr, rd, wdata} = {a, w, !w, d};
    @(negedge i_clk);
    {addr, wr, rd, wdata} = {~a, 1'b0, 1'b0, ~d};
    q = rdata;
  endtask
endmodule

// ---- tb/phy_control_a_chk.sv ----
// port checker for the upper half of control register a
module phy_control_a_chk (
  input logic i_clk, i_reset, i_ce, i_rd, i_cm_maintenance_state, i_configuration_override,
  input logic [4:0] i_addr, i_tx_symbol, i_maintenance_symbol, o_symbol_transmit_out,
  input logic [15:0] o_rdata,
  input logic [9:0] i_rx_data, o_rx_byte, i_mac_transmit_byte,
  input logic o_parity_error, i_violation_detected, o_violation_count_event,
  input logic i_min_gap_detected, i_min_detector_event, o_minimum_idle_count_event,
  input logic i_use_maintenance_symbol, o_external_loop_pin_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  chk_rdata_idle: assert property (!($past(i_rd) && $past(i_ce) && $past(i_addr) == 5'h00)
    |-> o_rdata == 16'h0000) else $error("read data not idle");
  chk_unused_zero: assert property (o_rdata[15] == 1'b0 && o_rdata[6:0] == 7'h00)
    else $error("unused bits read nonzero");
  chk_reset_outs: assert property ($past(i_reset) |-> o_external_loop_pin_n
    && o_rdata == 16'h0000) else $error("outputs wrong after reset");
  chk_scrub_idle: assert property (!$past(i_reset) && $past(i_ce) && !$past(i_cm_maintenance_state)
    && !$past(i_configuration_override) |-> o_rx_byte == $past(i_rx_data))
    else $error("receive byte altered");
  chk_tx_symbol: assert property (!$past(i_reset) && $past(i_ce) |-> o_symbol_transmit_out
    == ($past(i_use_maintenance_symbol) ? $past(i_maintenance_symbol) : $past(i_tx_symbol)))
    else $error("transmit symbol wrong");
  chk_parity_cause: assert property (o_parity_error |-> ^$past(i_mac_transmit_byte))
    else $error("parity error on even byte");
  chk_viol_cause: assert property (o_violation_count_event |-> $past(i_violation_detected))
    else $error("violation event without cause");
  chk_mini_cause: assert property (o_minimum_idle_count_event |-> $past(i_min_gap_detected)
    || $past(i_min_detector_event)) else $error("idle event without cause");
  chk_detector_pass: assert property (i_min_detector_event && i_ce |=>
    o_minimum_idle_count_event) else $error("detector event lost");
endmodule
bind phy_control_reg_a_upper phy_control_a_chk chk_u (.*);

// ---- tb/tb_phy_control_reg_a_upper.sv ----
// self-checking bench for the upper half of control register a
module tb_phy_control_reg_a_upper;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 0, i_reset = 1, i_cm_off = 1, i_cm_maintenance_state = 0, i_configuration_override = 0;
  logic i_use_maintenance_symbol = 0, i_violation_detected = 0, i_min_gap_detected = 0;
  logic i_min_detector_event = 0, i_wr, i_rd, i_ce = 1, i_cm_noise_timing = 0;
  logic [1:0] i_line_state = 2'h0;
  logic [15:0] i_noise_max_reload = 16'h0000, t0;
  wire [15:0] o_noise_event_timer, o_connection_timer;
  wire o_noise_timer_expired_flag;
  logic [4:0] i_addr, i_tx_symbol = 5'h0A, i_maintenance_symbol = 5'h15;
  logic [9:0] i_rx_data = 10'h155, i_mac_transmit_byte = 10'h000;
  logic [15:0] i_wdata, q;
  wire [15:0] o_rdata;
  wire [9:0] o_rx_byte;
  wire [4:0] o_symbol_transmit_out;
  wire o_parity_error, o_violation_count_event, o_minimum_idle_count_event;
  wire o_external_loop_pin_n;
  int mismatches = 0, n_checks = 0, ev;
  np_model np_u (.i_clk(i_clk), .addr(i_addr), .wr(i_wr), .rd(i_rd), .wdata(i_wdata),
    .rdata(o_rdata));
  phy_control_reg_a_upper dut_u (.*);
  initial forever #50 i_clk = ~i_clk;
  task automatic cmp(input logic [15:0] got, exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [15:0] d, input logic [4:0] a = 5'h00);
    np_u.access(1'b1, a, d, q);
  endtask
  task automatic rchk(input logic [15:0] exp);
    np_u.access(1'b0, 5'h00, 16'h0000, q);
    cmp(q, exp);
  endtask
  task automatic pulses(input int sel, n);
    ev = 0;
    repeat (n)
    begin
      @(negedge i_clk);
      {i_violation_detected, i_min_gap_detected, i_min_detector_event} = 3'b100 >> sel;
      @(negedge i_clk);
      {i_violation_detected, i_min_gap_detected, i_min_detector_event} = 3'b000;
      ev += ((sel == 0 ? o_violation_count_event : o_minimum_idle_count_event) === 1'b1);
    end
  endtask
  task automatic do_reset;
    @(negedge i_clk);
    i_reset = 1;
    repeat (5) @(negedge i_clk);
    i_reset = 0;
  endtask
  task automatic t_access;
    rchk(16'h0000);
    cmp(o_external_loop_pin_n, 1);
    wreg(16'hFFFF);
    rchk(16'h7F80);
    cmp(o_external_loop_pin_n, 0);
    wreg(16'h0000, 5'h01);
    rchk(16'h7F80);
    i_cm_off = 0;
    wreg(16'h0000);
    rchk(16'h3000);
    i_cm_maintenance_state = 1;
    wreg(16'h0000);
    rchk(16'h0000);
    cmp(o_external_loop_pin_n, 1);
  endtask
  task automatic t_scrub;
    wreg(16'h0800);
    @(negedge i_clk);
    cmp(o_rx_byte, 10'h3FF);
    cmp(o_symbol_transmit_out, 5'h0A);
    i_cm_maintenance_state = 0;
    @(negedge i_clk);
    cmp(o_rx_byte, 10'h155);
    i_configuration_override = 1;
    @(negedge i_clk);
    cmp(o_rx_byte, 10'h3FF);
    {i_configuration_override, i_cm_maintenance_state} = 2'b01;
  endtask
  task automatic t_parity;
    wreg(16'h0400);
    i_mac_transmit_byte = 10'h001;
    @(negedge i_clk);
    cmp(o_parity_error, 1);
    i_mac_transmit_byte = 10'h003;
    @(negedge i_clk);
    cmp(o_parity_error, 0);
    i_mac_transmit_byte = 10'h001;
    wreg(16'h0000);
    @(negedge i_clk);
    cmp(o_parity_error, 0);
  endtask
  task automatic t_counts;
    do_reset;
    wreg(16'h0300);
    pulses(0, 255);
    cmp(ev, 0);
    pulses(0, 1);
    cmp(ev, 1);
    pulses(1, 15);
    cmp(ev, 0);
    pulses(1, 1);
    cmp(ev, 1);
    pulses(2, 2);
    cmp(ev, 2);
    wreg(16'h0000);
    pulses(0, 3);
    cmp(ev, 3);
    pulses(1, 3);
    cmp(ev, 3);
  endtask
  task automatic t_noise;
    wreg(16'h6000);
    i_noise_max_reload = 16'hFFFC;
    i_line_state = 2'h1;
    @(negedge i_clk);
    cmp(o_noise_event_timer, 16'hFFFC);
    repeat (3) @(negedge i_clk);
    cmp(o_noise_event_timer, 16'hFFFF);
    cmp(o_noise_timer_expired_flag, 0);
    @(negedge i_clk);
    cmp(o_noise_timer_expired_flag, 1);
    i_line_state = 2'h0;
    wreg(16'h2000);
    i_noise_max_reload = 16'h0010;
    i_line_state = 2'h2;
    repeat (2) @(negedge i_clk);
    cmp(o_noise_event_timer, 16'hFFFF);
    i_line_state = 2'h0;
    wreg(16'h4000);
    i_line_state = 2'h3;
    @(negedge i_clk);
    cmp(o_noise_event_timer, 16'h0010);
    repeat (8) @(negedge i_clk);
    cmp(o_noise_event_timer, 16'h0012);
    i_line_state = 2'h0;
  endtask
  task automatic t_conn;
    wreg(16'h1000);
    t0 = o_connection_timer;
    repeat (8) @(negedge i_clk);
    cmp(o_connection_timer, t0 + 16'h0008);
    wreg(16'h0000);
    t0 = o_connection_timer;
    repeat (256) @(negedge i_clk);
    cmp(o_connection_timer, t0 + 16'h0001);
  endtask
  task automatic t_ce;
    i_ce = 0;
    wreg(16'h0080);
    cmp(o_external_loop_pin_n, 1);
    i_ce = 1;
    rchk(16'h0000);
  endtask
  task automatic give_verdict;
    if (mismatches == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    do_reset;
    t_access;
    t_scrub;
    t_parity;
    t_counts;
    t_noise;
    t_conn;
    t_ce;
    give_verdict;
  end
  initial
  begin
    #1000000;
    mismatches++;
    give_verdict;
  end
endmodule
